/* File: hw/tec_pkg.sv */
// Constants and types shared by the 8-bit timer/event counter
package tec_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] TEC_ADDR_COMPARE = 16'hff52;
  localparam logic [15:0] TEC_ADDR_MODE = 16'hff53;
  localparam logic [15:0] TEC_ADDR_COUNT = 16'hff54;

  // ---------------------------------------------------------------
  // Mode control fields and reset values
  // ---------------------------------------------------------------
  localparam int TEC_BIT_RUN = 7;
  localparam int TEC_BIT_PWM = 6;
  localparam int TEC_BIT_CSEL_HI = 2;
  localparam int TEC_BIT_CSEL_LO = 1;
  localparam int TEC_BIT_OE = 0;
  localparam logic [7:0] TEC_MODE_WMASK = 8'hc7;
  localparam logic [7:0] TEC_MODE_RESET = 8'h00;
  localparam logic [7:0] TEC_COUNT_RESET = 8'h00;
  localparam logic [7:0] TEC_COUNT_MAX = 8'hff;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int TEC_SYS_CLOCK_HZ = 10_000_000;
  localparam int TEC_PRESCALE_RATIO = 256;
  localparam int TEC_PRESCALE_W = $clog2(TEC_PRESCALE_RATIO);
  localparam logic [TEC_PRESCALE_W-1:0] TEC_PRESCALE_LAST =
    TEC_PRESCALE_W'(TEC_PRESCALE_RATIO - 1);

  // Count source selection codes
  typedef enum logic [1:0] {
    TEC_SRC_SYSCLK = 2'b00,
    TEC_SRC_DIV256 = 2'b01,
    TEC_SRC_EV_RISE = 2'b10,
    TEC_SRC_EV_FALL = 2'b11
  } tec_src_t;

  // CPU memory access carried into the block
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tec_bus_req_t;

  // Shared pin seen from the port side
  typedef struct packed {
    logic port_data;
    logic port_drive;
  } tec_port_t;

endpackage : tec_pkg

/* File: hw/tec_count_source.sv */
// Count-clock source: prescaler, pin synchroniser and edge select
`timescale 1ns/100ps
`default_nettype none

module tec_count_source
  import tec_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic event_pin, // Raw external count input
  input var tec_pkg::tec_src_t src, // Selected count source
  output logic tick // One-cycle count enable
);

  typedef struct packed {
    logic [TEC_PRESCALE_W-1:0] pre;
    logic sync1;
    logic sync2;
    logic last;
    logic tick;
  } tec_src_state_t;

  tec_src_state_t r;
  tec_src_state_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.pre = r.pre + TEC_PRESCALE_W'(1);
    next_r.sync1 = event_pin;
    next_r.sync2 = r.sync1;
    next_r.last = r.sync2;
    case (src)
      TEC_SRC_SYSCLK: next_r.tick = 1'b1;
      TEC_SRC_DIV256: next_r.tick = (r.pre == TEC_PRESCALE_LAST);
      TEC_SRC_EV_RISE: next_r.tick = r.sync2 & ~r.last;
      TEC_SRC_EV_FALL: next_r.tick = ~r.sync2 & r.last;
      default: next_r.tick = 1'b0;
    endcase
    if (srst)
    begin
      next_r = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    r <= next_r;
  end

  // Registered tick costs one cycle of latency but keeps the path short
  assign tick = r.tick;

endmodule : tec_count_source

`default_nettype wire

/* File: hw/tec_timer.sv */
// 8-bit timer/event counter with compare, square wave and PWM output
`timescale 1ns/100ps
`default_nettype none

module tec_timer
  import tec_pkg::*;
(
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic srst, // Synchronous reset, active high
  input var tec_pkg::tec_bus_req_t bus_req, // CPU memory access
  output logic [7:0] bus_rdata, // Read data, registered
  input var tec_pkg::tec_port_t port_ctl, // Port latch and direction
  input wire logic event_input_pin_in, // Shared pin level
  output logic timer_output_pin_out, // Shared pin drive value
  output logic timer_output_pin_oe_n, // Shared pin enable, low drives
  output logic match_interrupt // Match request, one-cycle pulse
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] compare_value;
    logic [7:0] count_value;
    logic wave;
    logic irq;
    logic [7:0] rdata;
  } tec_state_t;

  tec_state_t r;
  tec_state_t next_r;
  logic tick;
  logic counter_run;
  logic pwm_mode_select;
  logic output_enable;
  logic external_src;
  logic match;
  logic [7:0] count_inc;
  logic sel_mode;
  logic sel_compare;
  logic sel_count;
  tec_src_t src;

  assign counter_run = r.mode[TEC_BIT_RUN];
  assign pwm_mode_select = r.mode[TEC_BIT_PWM];
  assign output_enable = r.mode[TEC_BIT_OE];
  assign src = tec_src_t'({r.mode[TEC_BIT_CSEL_HI], r.mode[TEC_BIT_CSEL_LO]});
  assign external_src = r.mode[TEC_BIT_CSEL_HI];
  assign match = (r.count_value == r.compare_value);
  // Wraps from ff to 00, which is the PWM period
  assign count_inc = r.count_value + 8'h01;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  // Full 16-bit match so neighbouring registers never alias
  assign sel_mode = (bus_req.addr == TEC_ADDR_MODE);
  assign sel_compare = (bus_req.addr == TEC_ADDR_COMPARE);
  assign sel_count = (bus_req.addr == TEC_ADDR_COUNT);

  // ---------------------------------------------------------------
  // Count source
  // ---------------------------------------------------------------
  // system clock, divide-by-256 prescaler or external pin edges feed the counter
  tec_count_source u_src (
    .sys_clk(sys_clk),
    .srst(srst),
    .event_pin(event_input_pin_in),
    .src(src),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.irq = 1'b0;
    if (!counter_run)
    begin
      next_r.count_value = TEC_COUNT_RESET;
      next_r.wave = 1'b0;
    end
    else if (tick)
    begin
      next_r.irq = match;
      if (pwm_mode_select)
      begin
        next_r.count_value = count_inc;
      end
      else if (match)
      begin
        next_r.count_value = TEC_COUNT_RESET;
        next_r.wave = ~r.wave;
      end
      else
      begin
        next_r.count_value = count_inc;
      end
    end
    if (!output_enable)
    begin
      next_r.wave = 1'b0;
    end

    // Mode writes act at once; there is no guard against a running change
    if (bus_req.wr && sel_mode)
    begin
      next_r.mode = bus_req.wdata & TEC_MODE_WMASK;
    end
    // A compare write while counting can match at once; software stops first
    if (bus_req.wr && sel_compare)
    begin
      next_r.compare_value = bus_req.wdata;
    end
    // The counter is read-only, so a write to it is dropped

    // Unmapped reads return zero; a read beside a write sees the old value
    if (bus_req.rd)
    begin
      if (sel_mode)
      begin
        next_r.rdata = r.mode;
      end
      else if (sel_compare)
      begin
        next_r.rdata = r.compare_value;
      end
      else if (sel_count)
      begin
        next_r.rdata = r.count_value;
      end
      else
      begin
        next_r.rdata = 8'h00;
      end
    end

    if (srst)
    begin
      next_r.mode = TEC_MODE_RESET;
      next_r.count_value = TEC_COUNT_RESET;
      next_r.wave = 1'b0;
      next_r.irq = 1'b0;
      next_r.rdata = 8'h00;
      next_r.compare_value = r.compare_value;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    r <= next_r;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus_rdata = r.rdata;
  assign match_interrupt = r.irq;

  // ---------------------------------------------------------------
  // Shared pin
  // ---------------------------------------------------------------
  // Pin mux is combinational so port writes reach the pin at once
  always_comb
  begin
    timer_output_pin_out = port_ctl.port_data;
    timer_output_pin_oe_n = ~port_ctl.port_drive;
    // timer drives pin only with internal count source
    if (output_enable && !external_src)
    begin
      timer_output_pin_oe_n = 1'b0;
      if (pwm_mode_select)
      begin
        timer_output_pin_out = counter_run &&
          (r.count_value < r.compare_value);
      end
      else
      begin
        timer_output_pin_out = r.wave;
      end
    end
  end

endmodule : tec_timer

`default_nettype wire

/* File: verif/tec_chk.sv */
// Port assertions for the 8-bit timer
`timescale 1ns/100ps
`default_nettype none

module tec_chk
  import tec_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic srst, // Reset
  input var tec_pkg::tec_bus_req_t bus_req, // Access
  input wire logic [7:0] bus_rdata, // Read data
  input var tec_pkg::tec_port_t port_ctl, // Port
  input wire logic timer_output_pin_out, // Pin value
  input wire logic timer_output_pin_oe_n, // Pin enable
  input wire logic match_interrupt // Match
);
  logic [7:0] md, cm;
  logic [17:0] gp, eg;
  logic sn;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Shadows; any write voids the gap check
  // ----------------------------------------
  always_comb eg = (md[6] ? 18'h100 : {10'h0, cm} + 18'h1) << (md[1] ? 8 : 0);
  always_ff @(posedge sys_clk)
  begin
    if (srst || (bus_req.wr && bus_req.addr == TEC_ADDR_MODE))
      md <= srst ? 8'h00 : bus_req.wdata & TEC_MODE_WMASK;
    if (bus_req.wr && bus_req.addr == TEC_ADDR_COMPARE)
      cm <= bus_req.wdata;
    sn <= !srst && !bus_req.wr && (sn || match_interrupt);
    gp <= (srst || match_interrupt) ? 18'h1 : gp + 18'h1;
  end
  property p_rdm;
    bus_req.rd && bus_req.addr == TEC_ADDR_MODE |=> bus_rdata == $past(md);
  endproperty
  a_rdm: assert property (p_rdm) else $error("mode read");
  property p_rst;
    $fell(srst) |-> bus_rdata == 8'h00 && !match_interrupt;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_prt;
    !md[0] |-> timer_output_pin_out == port_ctl.port_data
      && timer_output_pin_oe_n == !port_ctl.port_drive;
  endproperty
  a_prt: assert property (p_prt) else $error("port pin");
  property p_ext;
    md[2] |-> timer_output_pin_oe_n == !port_ctl.port_drive;
  endproperty
  a_ext: assert property (p_ext) else $error("ext pin");
  property p_drv;
    md[0] && !md[2] |-> !timer_output_pin_oe_n;
  endproperty
  a_drv: assert property (p_drv) else $error("no drive");
  property p_idl;
    md[0] && !md[2] && !md[7] && !$past(md[7]) |-> !timer_output_pin_out;
  endproperty
  a_idl: assert property (p_idl) else $error("idle pin");
  property p_stp;
    !md[7] && !$past(md[7]) |-> !match_interrupt;
  endproperty
  a_stp: assert property (p_stp) else $error("stopped match");
  property p_gap;
    match_interrupt && sn && md[7] && !md[2] |-> gp == eg;
  endproperty
  a_gap: assert property (p_gap) else $error("match period");
  c_int: cover property (match_interrupt && md == 8'h80);
  c_pwm: cover property (match_interrupt && md[6]);
  c_sq: cover property (match_interrupt && md == 8'h81);
endmodule : tec_chk

`default_nettype wire

/* File: verif/tec_ev_src.sv */
// Event source and load on the shared pin
`timescale 1ns/100ps
`default_nettype none

module tec_ev_src
(
  input wire logic pin_out, // Timer drive value
  input wire logic oe_n, // Timer enable, low drives
  output logic pin // Resolved pin level
);
  logic src = 1'b0;
  // source yields the wire to the timer
  assign pin = oe_n ? src : pin_out;
  // Pulses end high: one more rise than falls
  task automatic send(input int n, input int p);
    src = 1'b0;
    repeat (n)
    begin
      #p src = 1'b1;
      #p src = 1'b0;
    end
    #p src = 1'b1;
  endtask : send
endmodule : tec_ev_src

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the 8-bit timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module tb
  import tec_pkg::*;
;
  logic sys_clk, srst, timer_output_pin_out, timer_output_pin_oe_n;
  logic event_input_pin_in, match_interrupt;
  logic [7:0] bus_rdata, d;
  tec_bus_req_t bus_req;
  tec_port_t port_ctl;
  int error_cnt = 0, n_tests = 0, n, g, hi;
  // Register model: expected read value per address, absent when unknown
  int mdl[int];
  tec_timer u_tec_timer (.sys_clk, .srst, .bus_req, .bus_rdata, .port_ctl,
    .event_input_pin_in, .timer_output_pin_out, .timer_output_pin_oe_n,
    .match_interrupt);
  tec_ev_src u_src (.pin_out(timer_output_pin_out),
    .oe_n(timer_output_pin_oe_n), .pin(event_input_pin_in));
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    bus_req.wr = 1'b1;
    bus_req.addr = a;
    bus_req.wdata = v;
    @(negedge sys_clk);
    bus_req.wr = 1'b0;
    if (a == TEC_ADDR_MODE)
      mdl[a] = v & TEC_MODE_WMASK;
    if (a == TEC_ADDR_COMPARE)
      mdl[a] = v;
    if (a == TEC_ADDR_MODE && !v[TEC_BIT_RUN])
      mdl[TEC_ADDR_COUNT] = TEC_COUNT_RESET;
    else if (a == TEC_ADDR_MODE)
      mdl.delete(TEC_ADDR_COUNT);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge sys_clk);
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    @(negedge sys_clk);
    bus_req.rd = 1'b0;
    d = bus_rdata;
    if (mdl.exists(a))
      `CHK("model", mdl[a], d)
  endtask : rd
  task automatic wm();
    g = 0;
    do @(negedge sys_clk); while (!match_interrupt && ++g < 70000);
  endtask : wm
  task automatic conclude();
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    srst = 1'b1;
    bus_req = '0;
    port_ctl = '0;
    n = $urandom(69);
    mdl[TEC_ADDR_MODE] = TEC_MODE_RESET;
    mdl[TEC_ADDR_COUNT] = TEC_COUNT_RESET;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    rd(TEC_ADDR_MODE); `CHK("mode", 8'h00, d)
    rd(TEC_ADDR_COUNT); `CHK("count", 8'h00, d)
    for (int i = 0; i < 3; i++)
    begin
      d = i == 0 ? 8'h00 : i == 2 ? 8'hff : 8'($urandom);
      wr(TEC_ADDR_COMPARE, d);
      n = d;
      rd(TEC_ADDR_COMPARE); `CHK("cmp", 8'(n), d)
    end
    wr(TEC_ADDR_MODE, 8'h7e);
    rd(TEC_ADDR_MODE); `CHK("mode", 8'h46, d)
    wr(TEC_ADDR_MODE, 8'h00);
    n = 1 + $urandom % 20;
    port_ctl = 2'($urandom);
    wr(TEC_ADDR_COMPARE, 8'(n));
    wr(TEC_ADDR_MODE, 8'h80);
    wm();
    wm(); `CHK("interval", n + 1, g + 1)
    wr(TEC_ADDR_MODE, 8'h00);
    rd(TEC_ADDR_COUNT); `CHK("stopped", 8'h00, d)
    wr(TEC_ADDR_COMPARE, 8'h01);
    wr(TEC_ADDR_MODE, 8'h02);
    wr(TEC_ADDR_MODE, 8'h82);
    wm();
    wm(); `CHK("div256", 512, g + 1)
    port_ctl.port_drive = 1'b0;
    for (int e = 1; e >= 0; e--)
    begin
      wr(TEC_ADDR_MODE, 8'h00);
      wr(TEC_ADDR_COMPARE, 8'hff);
      wr(TEC_ADDR_MODE, 8'(8'h04 | e << 1));
      wr(TEC_ADDR_MODE, 8'(8'h84 | e << 1));
      n = 3 + $urandom % 5;
      // Whole periods keep pin edges on falling clock edges
      u_src.send(n, 100 * $urandom_range(3, 9));
      repeat (6) @(negedge sys_clk);
      rd(TEC_ADDR_COUNT); `CHK("events", 8'(n + 1 - e), d)
    end
    n = 1 + $urandom % 10;
    wr(TEC_ADDR_MODE, 8'h00);
    wr(TEC_ADDR_COMPARE, 8'(n));
    wr(TEC_ADDR_MODE, 8'h01); `CHK("sq0", 1'b0, timer_output_pin_out)
    wr(TEC_ADDR_MODE, 8'h81);
    for (int k = 1; k < 5; k++)
    begin
      wm(); `CHK("sq", 1'(k), timer_output_pin_out)
    end
    n = 1 + $urandom % 255;
    wr(TEC_ADDR_MODE, 8'h00);
    wr(TEC_ADDR_COMPARE, 8'(n));
    wr(TEC_ADDR_MODE, 8'h41);
    wr(TEC_ADDR_MODE, 8'hc1);
    repeat (300) @(negedge sys_clk);
    hi = 0;
    repeat (512) @(negedge sys_clk) hi += timer_output_pin_out;
    `CHK("pwm", 2 * n, hi)
    wr(TEC_ADDR_MODE, 8'h00);
    conclude();
  end
endmodule : tb

bind tec_timer tec_chk u_chk (.sys_clk, .srst, .bus_req, .bus_rdata,
  .port_ctl, .timer_output_pin_out, .timer_output_pin_oe_n, .match_interrupt);

`default_nettype wire
